// ### csfr_checker.sv
// assertions on the ports of the charger status and fault register bank
// assumes one clock domain and the active high reset of csfr_regs
`timescale 1ns/1ps
`default_nettype none

module csfr_checker #(
   parameter int CYCLES_PER_SEC = 10
) (
   // clock and reset
   input wire logic       i_clk_sys,
   input wire logic       i_rst,
   // serial bus and supply
   input wire logic       i_scl,
   input wire logic       o_sda_oe_n,
   input wire logic       i_input_valid_flag,
   // fault events
   input wire logic       i_battery_below_short,
   input wire logic       i_overtemp_low_event,
   input wire logic       i_overtemp_high_event,
   // design outputs
   input wire logic [2:0] o_short_voltage_select,
   input wire logic [2:0] o_short_timeout_select,
   input wire logic [7:0] o_fault_flags
);
   // ----------------------------------------------------------------
   // helper logic
   // ----------------------------------------------------------------
   localparam int TMO_S [8] = '{1, 2, 4, 10, 30, 60, 120, 180};
   int low_run_ff;
   int exp_run;
   assign exp_run = TMO_S[o_short_timeout_select] * CYCLES_PER_SEC;
   // cycles in a row with the battery below the short threshold
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         low_run_ff <= 0;
      end else begin
         low_run_ff <= i_battery_below_short ? low_run_ff + 1 : 0;
      end
   end
   // ----------------------------------------------------------------
   // properties
   // ----------------------------------------------------------------
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_rst);
   property p_unused_zero;
      o_fault_flags[7:4] == 4'h0 && o_fault_flags[2] == 1'b0;
   endproperty
   property p_otl_set;
      i_overtemp_low_event |=> o_fault_flags[1];
   endproperty
   property p_oth_set;
      i_overtemp_high_event |=> o_fault_flags[0];
   endproperty
   property p_otl_cause;
      $rose(o_fault_flags[1]) |-> $past(i_overtemp_low_event);
   endproperty
   property p_flt_clear;
      (|($past(o_fault_flags) & ~o_fault_flags)) |-> $fell(o_sda_oe_n)
         || !$past(i_input_valid_flag) || !$past(i_input_valid_flag, 2);
   endproperty
   property p_cfg_write;
      !$stable({o_short_timeout_select, o_short_voltage_select})
         |-> $fell(o_sda_oe_n);
   endproperty
   property p_short_time;
      $rose(o_fault_flags[3])
         |-> low_run_ff >= exp_run - 1 && low_run_ff <= exp_run + 3;
   endproperty
   property p_reset_vals;
      $fell(i_rst) |-> o_short_timeout_select == 3'h4
         && o_short_voltage_select == 3'h4 && o_fault_flags == 8'h00;
   endproperty
   property p_sda_low;
      $changed(o_sda_oe_n) |-> !$past(i_scl);
   endproperty
   a_unused_zero: assert property (p_unused_zero)
      else $error("unused fault bits not zero");
   a_otl_set: assert property (p_otl_set)
      else $error("lower overtemp fault not set");
   a_oth_set: assert property (p_oth_set)
      else $error("higher overtemp fault not set");
   a_otl_cause: assert property (p_otl_cause)
      else $error("lower overtemp fault set without event");
   a_flt_clear: assert property (p_flt_clear)
      else $error("fault bit cleared without cause");
   a_cfg_write: assert property (p_cfg_write)
      else $error("short config changed without write");
   a_short_time: assert property (p_short_time)
      else $error("battery short fault at wrong time");
   a_reset_vals: assert property (p_reset_vals)
      else $error("wrong values after reset");
   a_sda_low: assert property (p_sda_low)
      else $error("sda driven change while scl high");
   c_short: cover property ($rose(o_fault_flags[3]));
   c_cfg: cover property (!$stable(o_short_voltage_select));
   c_clear: cover property ($fell(o_fault_flags[0]));
endmodule // csfr_checker
`default_nettype wire

// ### csfr_defines.svh
// offsets, field positions, reset values and timing counts of the
// charger status and fault register bank; included by bare name
`ifndef CSFR_DEFINES_SVH
`define CSFR_DEFINES_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define CSFR_ADDR_STATUS_ONE   8'h0B
`define CSFR_ADDR_STATUS_TWO   8'h0C
`define CSFR_ADDR_FAULT        8'h0D
`define CSFR_ADDR_SHORT_CFG    8'h10

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CSFR_FLT_BAT_SHORT     3
`define CSFR_FLT_OT_LOW        1
`define CSFR_FLT_OT_HIGH       0
`define CSFR_CFG_TMO_MSB       7
`define CSFR_CFG_TMO_LSB       5
`define CSFR_CFG_VSEL_MSB      2
`define CSFR_CFG_VSEL_LSB      0

// ----------------------------------------------------------------
// codes and reset values
// ----------------------------------------------------------------
`define CSFR_CHG_COMPLETE      3'h4
`define CSFR_TMO_RESET         3'h4
`define CSFR_VSEL_RESET        3'h4
// serial slave address, arbitrary value
`define CSFR_DEV_ADDR          7'h14

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CSFR_CLK_PERIOD_NS     25
`define CSFR_SECOND_NS         1000000000
`define CSFR_CYCLES_PER_SEC    (`CSFR_SECOND_NS / `CSFR_CLK_PERIOD_NS)
`define CSFR_TMO_S0            8'h01
`define CSFR_TMO_S1            8'h02
`define CSFR_TMO_S2            8'h04
`define CSFR_TMO_S3            8'h0A
`define CSFR_TMO_S4            8'h1E
`define CSFR_TMO_S5            8'h3C
`define CSFR_TMO_S6            8'h78
`define CSFR_TMO_S7            8'hB4

`endif

// ### csfr_host_model.sv
// serial bus master standing in for the host processor
// assumes a pull-up on sda; the bench resolves the wire
`timescale 1ns/1ps
`default_nettype none
`include "csfr_defines.svh"

module csfr_host_model (
   // clock
   input  wire logic i_clk_sys,
   // serial bus
   input  wire logic i_sda,
   output var  logic o_scl,
   output var  logic o_sda_oe_n
);
   initial begin
      o_scl = 1'b1;
      o_sda_oe_n = 1'b1;
   end
   // set both lines after a falling edge, then wait n cycles
   task automatic phase(input logic c, input logic d, input int n);
      o_scl = c;
      o_sda_oe_n = d;
      repeat (n) @(negedge i_clk_sys);
   endtask
   task automatic start_c();
      phase(1'b0, 1'b1, 2);
      phase(1'b1, 1'b1, 4);
      phase(1'b1, 1'b0, 4);
      phase(1'b0, 1'b0, 2);
   endtask
   task automatic stop_c();
      phase(1'b0, 1'b0, 2);
      phase(1'b1, 1'b0, 4);
      phase(1'b1, 1'b1, 4);
   endtask
   task automatic wbyte(input logic [7:0] b, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         phase(1'b0, b[i], 2);
         phase(1'b1, b[i], 4);
         phase(1'b0, b[i], 2);
      end
      phase(1'b0, 1'b1, 2);
      phase(1'b1, 1'b1, 2);
      ack = ~i_sda;
      phase(1'b1, 1'b1, 2);
      phase(1'b0, 1'b1, 2);
   endtask
   task automatic rbyte(input logic mack, output logic [7:0] b);
      for (int i = 7; i >= 0; i--) begin
         phase(1'b0, 1'b1, 2);
         phase(1'b1, 1'b1, 2);
         b[i] = i_sda;
         phase(1'b1, 1'b1, 2);
         phase(1'b0, 1'b1, 2);
      end
      phase(1'b0, ~mack, 2);
      phase(1'b1, ~mack, 4);
      phase(1'b0, ~mack, 2);
   endtask
   task automatic write_reg(input logic [7:0] a, input logic [7:0] d,
                            output logic ok);
      logic a1;
      logic a2;
      logic a3;
      start_c();
      wbyte({`CSFR_DEV_ADDR, 1'b0}, a1);
      wbyte(a, a2);
      wbyte(d, a3);
      stop_c();
      ok = a1 & a2 & a3;
   endtask
   task automatic read_reg(input logic [7:0] a, output logic [7:0] d,
                           output logic ok);
      logic a1;
      logic a2;
      logic a3;
      start_c();
      wbyte({`CSFR_DEV_ADDR, 1'b0}, a1);
      wbyte(a, a2);
      start_c();
      wbyte({`CSFR_DEV_ADDR, 1'b1}, a3);
      rbyte(1'b0, d);
      stop_c();
      ok = a1 & a2 & a3;
   endtask
endmodule // csfr_host_model
`default_nettype wire

// ### csfr_pkg.sv
// types of the charger status and fault register bank
// assumes nothing beyond a SystemVerilog compiler
package csfr_pkg;

   typedef enum logic [3:0] {
      I2C_IDLE,
      I2C_ADDR,
      I2C_ADDR_ACK,
      I2C_PTR,
      I2C_PTR_ACK,
      I2C_WR,
      I2C_WR_ACK,
      I2C_RD,
      I2C_RD_ACK
   } csfr_i2c_state_type;

   typedef struct packed {
      csfr_i2c_state_type st;
      logic               scl_q;
      logic               sda_q;
      logic [7:0]         shift;
      logic [3:0]         bit_cnt;
      logic [7:0]         ptr;
      logic               rw;
      logic               mack;
      logic               sda_oe_n;
      logic               input_valid_flag_q;
      logic               charge_complete_latch;
      logic               bat_short;
      logic               ot_low;
      logic               ot_high;
      logic [2:0]         tmo_sel;
      logic [2:0]         vsel;
   } csfr_regs_state_type;

   typedef struct packed {
      logic [25:0] tick_cnt;
      logic [7:0]  sec_cnt;
      logic        done;
      logic        evt;
   } csfr_timer_state_type;

endpackage

// ### csfr_regs.sv
// charger status and fault register bank behind a two-wire serial slave
// assumes scl and sda samples are synchronous to i_clk_sys and that
// the pad resolves sda from o_sda_oe_n (low pulls the line low)
//
// Summary of operation
// - status one bits 7 and 6: overvoltage and input-valid flags, read only.
// - status one bit 5: input current limited by blocking transistor.
// - status one bit 4: charge current reduced by die temperature limit.
// - status one bit 3: charge complete, latched until supply power cycle.
// - status one bits 2:0: charger state code from the charge loop.
// - status two bits 7:5: thermistor state code.
// - status two bit 3: recharge needed, only when disabled and complete.
// - status two bits 2:0: battery level code.
// - fault bit 3 sets on a battery short, reset value zero.
// - fault bits 1 and 0: lower and higher overtemperature faults.
// - fault bits clear on write one or supply power cycle.
// - short config bits 7:5 select timeout 1 to 180 seconds.
// - short config bits 2:0 select threshold 2.0 to 2.7 volts.
// - status one at 0x0B and status two at 0x0C, readable.
// - battery short config at 0x10, readable and writable.
`timescale 1ns/1ps
`default_nettype none
`include "csfr_defines.svh"

module csfr_regs
   import csfr_pkg::*;
#(
   parameter int CYCLES_PER_SEC = `CSFR_CYCLES_PER_SEC
) (
   // clock and reset
   input  wire logic       i_clk_sys,
   input  wire logic       i_rst,
   // serial bus
   input  wire logic       i_scl,
   input  wire logic       i_sda,
   output logic            o_sda_o,
   output logic            o_sda_oe_n,
   // supply input status
   input  wire logic       i_input_overvoltage_flag,
   input  wire logic       i_input_valid_flag,
   input  wire logic       i_input_current_limited_flag,
   input  wire logic       i_thermal_limit_flag,
   // charge loop status
   input  wire logic       i_charge_end,
   input  wire logic [2:0] i_charger_state,
   input  wire logic [2:0] i_thermistor_state_code,
   input  wire logic       i_recharge_disable,
   input  wire logic       i_battery_below_recharge,
   input  wire logic [2:0] i_battery_level,
   // fault events
   input  wire logic       i_battery_below_short,
   input  wire logic       i_overtemp_low_event,
   input  wire logic       i_overtemp_high_event,
   // configuration and fault outputs
   output logic [2:0]      o_short_voltage_select,
   output logic [2:0]      o_short_timeout_select,
   output logic [7:0]      o_fault_flags
);

   csfr_regs_state_type state_ff;
   csfr_regs_state_type nxt_state;

   logic short_evt;
   logic scl_rise;
   logic scl_fall;
   logic bus_start;
   logic bus_stop;
   logic power_cycle;
   logic wr_en;
   logic [7:0] wr_data;
   logic [7:0] wr_addr;

   // ----------------------------------------------------------------
   // battery short timing
   // ----------------------------------------------------------------
   csfr_short_timer #(
      .CYCLES_PER_SEC (CYCLES_PER_SEC)
   ) u_short_timer (
      .i_clk_sys        (i_clk_sys),
      .i_rst            (i_rst),
      .i_below_short    (i_battery_below_short),
      .i_timeout_select (state_ff.tmo_sel),
      .o_short_detected (short_evt)
   );

   // ----------------------------------------------------------------
   // register read decode
   // ----------------------------------------------------------------
   function automatic logic [7:0] reg_read(input logic [7:0] a);
      logic rch;
      rch = 1'b0;
      reg_read = 8'h00;
      rch = i_recharge_disable && i_battery_below_recharge &&
            (i_charger_state == `CSFR_CHG_COMPLETE);
      case (a)
         `CSFR_ADDR_STATUS_ONE: begin
            reg_read = {i_input_overvoltage_flag,
                        i_input_valid_flag,
                        i_input_current_limited_flag,
                        i_thermal_limit_flag,
                        state_ff.charge_complete_latch,
                        i_charger_state};
         end
         `CSFR_ADDR_STATUS_TWO: begin
            reg_read = {i_thermistor_state_code,
                        1'b0,
                        rch,
                        i_battery_level};
         end
         `CSFR_ADDR_FAULT: begin
            reg_read = {4'h0, state_ff.bat_short, 1'b0,
                        state_ff.ot_low, state_ff.ot_high};
         end
         `CSFR_ADDR_SHORT_CFG: begin
            reg_read = {state_ff.tmo_sel, 2'b00, state_ff.vsel};
         end
         default: begin
            reg_read = 8'h00;
         end
      endcase
   endfunction

   // ----------------------------------------------------------------
   // bus conditions
   // ----------------------------------------------------------------
   assign scl_rise    = i_scl && !state_ff.scl_q;
   assign scl_fall    = !i_scl && state_ff.scl_q;
   assign bus_start   = i_scl && state_ff.scl_q && state_ff.sda_q && !i_sda;
   assign bus_stop    = i_scl && state_ff.scl_q && !state_ff.sda_q && i_sda;
   assign power_cycle = state_ff.input_valid_flag_q && !i_input_valid_flag;

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      nxt_state          = state_ff;
      nxt_state.scl_q    = i_scl;
      nxt_state.sda_q    = i_sda;
      nxt_state.input_valid_flag_q = i_input_valid_flag;
      wr_en              = 1'b0;
      wr_data            = state_ff.shift;
      wr_addr            = state_ff.ptr;

      if (bus_stop) begin
         nxt_state.st       = I2C_IDLE;
         nxt_state.sda_oe_n = 1'b1;
      end else if (bus_start) begin
         nxt_state.st       = I2C_ADDR;
         nxt_state.bit_cnt  = 4'h0;
         nxt_state.sda_oe_n = 1'b1;
      end else begin
         case (state_ff.st)
            I2C_IDLE: begin
               nxt_state.sda_oe_n = 1'b1;
            end
            I2C_ADDR, I2C_PTR, I2C_WR: begin
               if (scl_rise && state_ff.bit_cnt != 4'h8) begin
                  nxt_state.shift   = {state_ff.shift[6:0], i_sda};
                  nxt_state.bit_cnt = state_ff.bit_cnt + 4'h1;
               end else if (scl_fall && state_ff.bit_cnt == 4'h8) begin
                  nxt_state.sda_oe_n = 1'b0;
                  if (state_ff.st == I2C_ADDR) begin
                     if (state_ff.shift[7:1] == `CSFR_DEV_ADDR) begin
                        nxt_state.rw = state_ff.shift[0];
                        nxt_state.st = I2C_ADDR_ACK;
                     end else begin
                        nxt_state.sda_oe_n = 1'b1;
                        nxt_state.st       = I2C_IDLE;
                     end
                  end else if (state_ff.st == I2C_PTR) begin
                     nxt_state.ptr = state_ff.shift;
                     nxt_state.st  = I2C_PTR_ACK;
                  end else begin
                     wr_en         = 1'b1;
                     nxt_state.ptr = state_ff.ptr + 8'h01;
                     nxt_state.st  = I2C_WR_ACK;
                  end
               end
            end
            I2C_ADDR_ACK, I2C_PTR_ACK, I2C_WR_ACK: begin
               if (scl_fall) begin
                  nxt_state.bit_cnt = 4'h0;
                  if (state_ff.st == I2C_ADDR_ACK && state_ff.rw) begin
                     nxt_state.shift    = reg_read(state_ff.ptr);
                     nxt_state.sda_oe_n = reg_read(state_ff.ptr) >= 8'h80;
                     nxt_state.ptr      = state_ff.ptr + 8'h01;
                     nxt_state.st       = I2C_RD;
                  end else begin
                     nxt_state.sda_oe_n = 1'b1;
                     nxt_state.st = (state_ff.st == I2C_ADDR_ACK) ?
                                    I2C_PTR : I2C_WR;
                  end
               end
            end
            I2C_RD: begin
               if (scl_fall) begin
                  nxt_state.bit_cnt = state_ff.bit_cnt + 4'h1;
                  if (state_ff.bit_cnt == 4'h7) begin
                     nxt_state.sda_oe_n = 1'b1;
                     nxt_state.st       = I2C_RD_ACK;
                  end else begin
                     nxt_state.shift    = {state_ff.shift[6:0], 1'b0};
                     nxt_state.sda_oe_n = state_ff.shift[6];
                  end
               end
            end
            I2C_RD_ACK: begin
               if (scl_rise) begin
                  nxt_state.mack = !i_sda;
               end else if (scl_fall) begin
                  if (state_ff.mack) begin
                     nxt_state.bit_cnt  = 4'h0;
                     nxt_state.shift    = reg_read(state_ff.ptr);
                     nxt_state.sda_oe_n = reg_read(state_ff.ptr) >= 8'h80;
                     nxt_state.ptr      = state_ff.ptr + 8'h01;
                     nxt_state.st       = I2C_RD;
                  end else begin
                     nxt_state.st = I2C_IDLE;
                  end
               end
            end
            default: begin
               nxt_state.st       = I2C_IDLE;
               nxt_state.sda_oe_n = 1'b1;
            end
         endcase
      end

      // charge complete latch: set wins over power cycle clear
      if (power_cycle) begin
         nxt_state.charge_complete_latch = 1'b0;
      end
      if (i_charge_end) begin
         nxt_state.charge_complete_latch = 1'b1;
      end

      // fault clears, then sets so a same-cycle event is kept
      if (power_cycle) begin
         nxt_state.bat_short = 1'b0;
         nxt_state.ot_low    = 1'b0;
         nxt_state.ot_high   = 1'b0;
      end
      if (wr_en && wr_addr == `CSFR_ADDR_FAULT) begin
         if (wr_data[`CSFR_FLT_BAT_SHORT]) begin
            nxt_state.bat_short = 1'b0;
         end
         if (wr_data[`CSFR_FLT_OT_LOW]) begin
            nxt_state.ot_low = 1'b0;
         end
         if (wr_data[`CSFR_FLT_OT_HIGH]) begin
            nxt_state.ot_high = 1'b0;
         end
      end
      if (short_evt) begin
         nxt_state.bat_short = 1'b1;
      end
      if (i_overtemp_low_event) begin
         nxt_state.ot_low = 1'b1;
      end
      if (i_overtemp_high_event) begin
         nxt_state.ot_high = 1'b1;
      end

      // only the config register stores data; fault bits clear on write one, others ignore writes
      if (wr_en && wr_addr == `CSFR_ADDR_SHORT_CFG) begin
         nxt_state.tmo_sel = wr_data[`CSFR_CFG_TMO_MSB:`CSFR_CFG_TMO_LSB];
         nxt_state.vsel = wr_data[`CSFR_CFG_VSEL_MSB:`CSFR_CFG_VSEL_LSB];
      end
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         state_ff          <= '0;
         state_ff.st       <= I2C_IDLE;
         state_ff.scl_q    <= 1'b1;
         state_ff.sda_q    <= 1'b1;
         state_ff.sda_oe_n <= 1'b1;
         state_ff.tmo_sel  <= `CSFR_TMO_RESET;
         state_ff.vsel     <= `CSFR_VSEL_RESET;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign o_sda_o                = 1'b0;
   assign o_sda_oe_n             = state_ff.sda_oe_n;
   assign o_short_voltage_select = state_ff.vsel;
   assign o_short_timeout_select = state_ff.tmo_sel;
   assign o_fault_flags = {4'h0, state_ff.bat_short, 1'b0,
                           state_ff.ot_low, state_ff.ot_high};

endmodule // csfr_regs

`default_nettype wire

// ### csfr_short_timer.sv
// battery short timeout timer: counts whole seconds while the battery
// sits below the short threshold and pulses once when time is up
// assumes the comparator input is synchronous to i_clk_sys
`timescale 1ns/1ps
`default_nettype none
`include "csfr_defines.svh"

module csfr_short_timer
   import csfr_pkg::*;
#(
   parameter int CYCLES_PER_SEC = `CSFR_CYCLES_PER_SEC
) (
   // clock and reset
   input  wire logic       i_clk_sys,
   input  wire logic       i_rst,
   // control
   input  wire logic       i_below_short,
   input  wire logic [2:0] i_timeout_select,
   // event
   output logic            o_short_detected
);

   localparam logic [25:0] TICK_LAST = 26'(CYCLES_PER_SEC - 1);

   csfr_timer_state_type state_ff;
   csfr_timer_state_type nxt_state;

   function automatic logic [7:0] timeout_secs(input logic [2:0] sel);
      case (sel)
         3'h0:    timeout_secs = `CSFR_TMO_S0;
         3'h1:    timeout_secs = `CSFR_TMO_S1;
         3'h2:    timeout_secs = `CSFR_TMO_S2;
         3'h3:    timeout_secs = `CSFR_TMO_S3;
         3'h4:    timeout_secs = `CSFR_TMO_S4;
         3'h5:    timeout_secs = `CSFR_TMO_S5;
         3'h6:    timeout_secs = `CSFR_TMO_S6;
         default: timeout_secs = `CSFR_TMO_S7;
      endcase
   endfunction

   always_comb begin
      nxt_state     = state_ff;
      nxt_state.evt = 1'b0;
      if (!i_below_short) begin
         nxt_state.tick_cnt = 26'h0;
         nxt_state.sec_cnt  = 8'h00;
         nxt_state.done     = 1'b0;
      end else if (!state_ff.done) begin
         if (state_ff.tick_cnt == TICK_LAST) begin
            nxt_state.tick_cnt = 26'h0;
            nxt_state.sec_cnt  = state_ff.sec_cnt + 8'h01;
            if ((state_ff.sec_cnt + 8'h01) >=
                timeout_secs(i_timeout_select)) begin
               nxt_state.evt  = 1'b1;
               nxt_state.done = 1'b1;
            end
         end else begin
            nxt_state.tick_cnt = state_ff.tick_cnt + 26'h1;
         end
      end
   end

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         state_ff <= '0;
      end else begin
         state_ff <= nxt_state;
      end
   end

   assign o_short_detected = state_ff.evt;

endmodule // csfr_short_timer

`default_nettype wire

// ### tb_top.sv
// self-checking bench of the charger status and fault register bank
// assumes csfr_regs, csfr_host_model and csfr_checker are compiled
`timescale 1ns/1ps
`default_nettype none
`include "csfr_defines.svh"
`define TB_CHK(nm, exp, got) begin checks_done++; \
   if ((got) !== (exp)) begin miscompares++; \
   $display("unexpected %s exp %h got %h", nm, exp, got); end end

module tb_top;
   logic clk = 1'b0, rst = 1'b1, ov = 1'b0, vok = 1'b1, ilim = 1'b0;
   logic therm = 1'b0, cend = 1'b0, dis = 1'b1, brch = 1'b0, bs = 1'b0;
   logic otl = 1'b0, oth = 1'b0;
   logic [2:0] cst = 3'h0, thr = 3'h0, lvl = 3'h0;
   wire scl, dut_oe_n, dut_sda_o, host_oe_n, sda;
   wire [2:0] vsel, tsel;
   wire [7:0] flt;
   int miscompares = 0;
   int checks_done = 0;
   // pull-up: released line reads high
   assign sda = dut_oe_n & host_oe_n;
   always #12.5 clk = ~clk;
   csfr_regs #(.CYCLES_PER_SEC(10)) dut_u (
      .i_clk_sys(clk), .i_rst(rst), .i_scl(scl), .i_sda(sda),
      .o_sda_o(dut_sda_o), .o_sda_oe_n(dut_oe_n),
      .i_input_overvoltage_flag(ov), .i_input_valid_flag(vok),
      .i_input_current_limited_flag(ilim), .i_thermal_limit_flag(therm),
      .i_charge_end(cend), .i_charger_state(cst),
      .i_thermistor_state_code(thr), .i_recharge_disable(dis),
      .i_battery_below_recharge(brch), .i_battery_level(lvl),
      .i_battery_below_short(bs), .i_overtemp_low_event(otl),
      .i_overtemp_high_event(oth), .o_short_voltage_select(vsel),
      .o_short_timeout_select(tsel), .o_fault_flags(flt));
   csfr_host_model host_u (
      .i_clk_sys(clk), .i_sda(sda), .o_scl(scl), .o_sda_oe_n(host_oe_n));
   task automatic give_verdict();
      if (miscompares == 0 && checks_done > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic ok;
      host_u.write_reg(a, d, ok);
      `TB_CHK("write ack", 1'b1, ok)
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e,
                     input string nm);
      logic ok;
      logic [7:0] d;
      host_u.read_reg(a, d, ok);
      `TB_CHK("read ack", 1'b1, ok)
      `TB_CHK(nm, e, d)
   endtask
   initial begin
      repeat (60000) @(posedge clk);
      miscompares++;
      give_verdict();
   end
   initial begin
      logic [7:0] e1;
      logic ack;
      repeat (16) @(negedge clk);
      rst = 1'b0;
      repeat (4) @(negedge clk);
      rd(`CSFR_ADDR_SHORT_CFG, 8'h84, "cfg reset");
      rd(`CSFR_ADDR_FAULT, 8'h00, "fault reset");
      rd(8'h0E, 8'h00, "unmapped");
      for (int i = 0; i < 8; i++) begin
         cst = 3'(i);
         ov = i[0];
         ilim = i[1];
         therm = i[2];
         thr = (i < 5) ? 3'(i) : 3'h7;
         lvl = 3'(i % 5);
         brch = ~i[0];
         e1 = {ov, 1'b1, ilim, therm, 1'b0, cst};
         rd(`CSFR_ADDR_STATUS_ONE, e1, "status one");
         rd(`CSFR_ADDR_STATUS_TWO, {thr, 1'b0, brch & (i == 4), lvl},
            "status two");
      end
      wr(`CSFR_ADDR_STATUS_ONE, 8'hFF);
      rd(`CSFR_ADDR_STATUS_ONE, e1, "status one ro");
      cend = 1'b1;
      @(negedge clk);
      cend = 1'b0;
      cst = 3'h4;
      dis = 1'b0;
      brch = 1'b1;
      rd(`CSFR_ADDR_STATUS_ONE, {ov, 1'b1, ilim, therm, 1'b1, cst},
         "latch");
      rd(`CSFR_ADDR_STATUS_TWO, {thr, 2'h0, lvl}, "rch off");
      otl = 1'b1;
      @(negedge clk);
      otl = 1'b0;
      oth = 1'b1;
      @(negedge clk);
      oth = 1'b0;
      `TB_CHK("fault port", 8'h03, flt)
      rd(`CSFR_ADDR_FAULT, 8'h03, "faults");
      wr(`CSFR_ADDR_FAULT, 8'hF6);
      rd(`CSFR_ADDR_FAULT, 8'h01, "w1c low");
      wr(`CSFR_ADDR_FAULT, 8'h01);
      `TB_CHK("w1c high", 8'h00, flt)
      wr(`CSFR_ADDR_SHORT_CFG, 8'h1B);
      rd(`CSFR_ADDR_SHORT_CFG, 8'h03, "cfg rw");
      `TB_CHK("vsel", 3'h3, vsel)
      `TB_CHK("tsel", 3'h0, tsel)
      bs = 1'b1;
      repeat (5) @(negedge clk);
      bs = 1'b0;
      repeat (20) @(negedge clk);
      `TB_CHK("short early", 8'h00, flt)
      bs = 1'b1;
      repeat (8) @(negedge clk);
      `TB_CHK("short wait", 8'h00, flt)
      repeat (6) @(negedge clk);
      `TB_CHK("short set", 8'h08, flt)
      bs = 1'b0;
      wr(`CSFR_ADDR_SHORT_CFG, 8'hE7);
      rd(`CSFR_ADDR_SHORT_CFG, 8'hE7, "cfg max");
      vok = 1'b0;
      repeat (3) @(negedge clk);
      vok = 1'b1;
      repeat (3) @(negedge clk);
      `TB_CHK("power cycle", 8'h00, flt)
      rd(`CSFR_ADDR_STATUS_ONE, {ov, 1'b1, ilim, therm, 1'b0, cst},
         "unlatch");
      host_u.start_c();
      host_u.wbyte({`CSFR_DEV_ADDR, 1'b0}, ack);
      host_u.wbyte(8'h0F, ack);
      host_u.start_c();
      host_u.wbyte({`CSFR_DEV_ADDR, 1'b1}, ack);
      host_u.rbyte(1'b1, e1);
      `TB_CHK("burst first", 8'h00, e1)
      host_u.rbyte(1'b0, e1);
      `TB_CHK("burst next", 8'hE7, e1)
      host_u.stop_c();
      host_u.start_c();
      host_u.wbyte(8'hA0, ack);
      host_u.stop_c();
      `TB_CHK("foreign addr", 1'b0, ack)
      `TB_CHK("sda out", 1'b0, dut_sda_o)
      give_verdict();
   end
endmodule // tb_top

bind csfr_regs csfr_checker #(.CYCLES_PER_SEC(CYCLES_PER_SEC)) chk_u (.*);
`default_nettype wire
